// ### rtl/sfc_pkg.sv
// Package: register map, field layout and encodings of the FIFO configuration block
package sfc_pkg;
  // Register byte offsets
  localparam logic [7:0] FIFO_CONFIG_OFFS = 8'h00;
  localparam logic [7:0] MODE_CTRL_OFFS   = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFS    = 8'h0C;
  localparam logic [7:0] FIFO_STATE_OFFS  = 8'h10;
  localparam logic [7:0] RX_QUEUE_OFFS    = 8'h14;

  // fifo_config fields
  localparam int CFG_FIFO_EN_BIT   = 0;
  localparam int CFG_AUTO_STOP_BIT = 1;
  localparam int CFG_RX_IRQ_BIT    = 2;
  localparam int CFG_TX_IRQ_BIT    = 3;
  localparam int CFG_RX_USAGE_BIT  = 4;
  localparam int CFG_WIDTH         = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // mode_ctrl fields
  localparam int MODE_RXE_BIT   = 0;
  localparam int MODE_TXE_BIT   = 1;
  localparam int MODE_DPX_LSB   = 2;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // rx_queue_ctrl fill-level field
  localparam logic [1:0] RXQ_RESET = 2'h0;

  // Interrupt status bits
  localparam int IRQ_TX_LEVEL_BIT = 0;
  localparam int IRQ_RX_LEVEL_BIT = 1;
  localparam int IRQ_RX_STOP_BIT  = 2;
  localparam int IRQ_TX_STOP_BIT  = 3;
  localparam int IRQ_WIDTH        = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // Depths in bytes
  localparam logic [2:0] DEPTH_HALF = 3'h4;
  localparam logic [2:0] DEPTH_FULL = 3'h2;

  typedef enum logic [1:0] {
    DPX_OFF     = 2'b00,
    DPX_HALF_RX = 2'b01,
    DPX_HALF_TX = 2'b10,
    DPX_FULL    = 2'b11
  } sfc_dpx_t;
endpackage : sfc_pkg

// ### rtl/sfc_sizer.sv
// Depth and threshold calculation from duplex and configuration
`timescale 1ns/100ps
`default_nettype none
module sfc_sizer (
  input  wire logic [1:0] duplex,
  input  wire logic       fifo_en,
  input  wire logic       rx_usage_select,
  input  wire logic [1:0] rx_fill_code,
  output logic      [2:0] rx_depth,
  output logic      [2:0] tx_depth,
  output logic      [2:0] rx_fill_level,
  output logic      [2:0] rx_used
);
  wire logic half_rx = duplex == sfc_pkg::DPX_HALF_RX;
  wire logic half_tx = duplex == sfc_pkg::DPX_HALF_TX;
  wire logic full    = duplex == sfc_pkg::DPX_FULL;
  wire logic rx_fifo_on = fifo_en && (half_rx || full);
  wire logic [2:0] half_lvl = (rx_fill_code == 2'h0) ? sfc_pkg::DEPTH_HALF : {1'b0, rx_fill_code};
  wire logic [2:0] full_lvl = rx_fill_code[0] ? 3'h1 : sfc_pkg::DEPTH_FULL;

  assign rx_depth = !fifo_en ? 3'h1 : half_rx ? sfc_pkg::DEPTH_HALF : full ? sfc_pkg::DEPTH_FULL : 3'h1;
  assign tx_depth = !fifo_en ? 3'h1 : half_tx ? sfc_pkg::DEPTH_HALF : full ? sfc_pkg::DEPTH_FULL : 3'h1;
  assign rx_fill_level = full ? full_lvl : half_lvl;
  assign rx_used = (rx_fifo_on && rx_usage_select) ? rx_fill_level : rx_depth;
endmodule : sfc_sizer
`default_nettype wire

// ### rtl/sfc_top.sv
// Serial channel FIFO configuration, sizing, auto-stop and interrupts
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Usage bit picks full depth or level
// - Transmit level interrupt gated by enable
// - Receive level interrupt gated by enable
// - Half receive full clears receive enable
// - Half transmit empty clears transmit enable
// - Full duplex: either condition clears both
// - Enable bit on sizes FIFO from duplex
// - Half duplex: 4 bytes, active direction
// - Full duplex: 2 plus 2 bytes
// - Transmit FIFO offers its full depth
// - Fill code maps to receive threshold
module sfc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  rx_count,
  input  wire logic [2:0]  tx_count,
  input  wire logic        rx_shift_full,
  input  wire logic        rx_buf_full,
  input  wire logic        tx_shift_empty,
  input  wire logic        tx_buf_empty,
  input  wire logic        rx_level_evt,
  input  wire logic        tx_level_evt,
  output logic             rx_enable,
  output logic             tx_enable,
  output logic      [2:0]  rx_depth,
  output logic      [2:0]  tx_depth,
  output logic      [2:0]  rx_used,
  output logic             irq
);
  logic [7:0] cfg_r;
  logic [3:0] mode_r;
  logic [1:0] rxq_r;
  logic [3:0] ist_r;
  logic [3:0] imask_r;
  logic [3:0] ist_nxt;
  logic [3:0] mode_nxt;
  logic [2:0] rx_fill_level;

  wire logic       wr_en   = psel && penable && pwrite;
  wire logic       sel_cfg = paddr == sfc_pkg::FIFO_CONFIG_OFFS;
  wire logic       sel_mod = paddr == sfc_pkg::MODE_CTRL_OFFS;
  wire logic       sel_ist = paddr == sfc_pkg::IRQ_STATUS_OFFS;
  wire logic       sel_msk = paddr == sfc_pkg::IRQ_MASK_OFFS;
  wire logic       sel_sta = paddr == sfc_pkg::FIFO_STATE_OFFS;
  wire logic       sel_rxq = paddr == sfc_pkg::RX_QUEUE_OFFS;
  wire logic       mapped  = sel_cfg | sel_mod | sel_ist | sel_msk | sel_sta | sel_rxq;
  wire logic [1:0] duplex  = mode_r[sfc_pkg::MODE_DPX_LSB +: 2];
  wire logic       fifo_en = cfg_r[sfc_pkg::CFG_FIFO_EN_BIT];
  wire logic       auto_xfer_stop  = fifo_en && cfg_r[sfc_pkg::CFG_AUTO_STOP_BIT];
  wire logic       tx_level_irq_en = fifo_en && cfg_r[sfc_pkg::CFG_TX_IRQ_BIT];
  wire logic       rx_level_irq_en = fifo_en && cfg_r[sfc_pkg::CFG_RX_IRQ_BIT];
  wire logic       full_dpx = duplex == sfc_pkg::DPX_FULL;
  wire logic       rx_full_cond = rx_shift_full && rx_buf_full && (rx_count >= rx_used);
  wire logic       tx_empty_cond = tx_shift_empty && tx_buf_empty && (tx_count == 3'h0);
  wire logic       rx_stop = auto_xfer_stop && ((duplex == sfc_pkg::DPX_HALF_RX && rx_full_cond) ||
                                                (full_dpx && (rx_full_cond || tx_empty_cond)));
  wire logic       tx_stop = auto_xfer_stop && ((duplex == sfc_pkg::DPX_HALF_TX && tx_empty_cond) ||
                                                (full_dpx && (rx_full_cond || tx_empty_cond)));
  wire logic [3:0] evt = {tx_stop && mode_r[sfc_pkg::MODE_TXE_BIT],
                          rx_stop && mode_r[sfc_pkg::MODE_RXE_BIT],
                          rx_level_evt && rx_level_irq_en,
                          tx_level_evt && tx_level_irq_en};
  wire logic [3:0] ist_clr = (wr_en && sel_ist) ? pwdata[3:0] : 4'h0;

  sfc_sizer u_sizer (
    .duplex          (duplex),
    .fifo_en         (fifo_en),
    .rx_usage_select (cfg_r[sfc_pkg::CFG_RX_USAGE_BIT]),
    .rx_fill_code    (rxq_r),
    .rx_depth        (rx_depth),
    .tx_depth        (tx_depth),
    .rx_fill_level   (rx_fill_level),
    .rx_used         (rx_used)
  );

  // Set wins over write-one clear
  assign ist_nxt = (ist_r & ~ist_clr) | evt;

  always_comb begin
    mode_nxt = mode_r;
    if (wr_en && sel_mod) begin
      mode_nxt = pwdata[3:0];
    end
    if (rx_stop) begin
      mode_nxt[sfc_pkg::MODE_RXE_BIT] = 1'b0;
    end
    if (tx_stop) begin
      mode_nxt[sfc_pkg::MODE_TXE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r   <= sfc_pkg::CFG_RESET;
      mode_r  <= sfc_pkg::MODE_RESET;
      rxq_r   <= sfc_pkg::RXQ_RESET;
      ist_r   <= sfc_pkg::IRQ_RESET;
      imask_r <= sfc_pkg::IRQ_RESET;
    end else begin
      mode_r <= mode_nxt;
      ist_r  <= ist_nxt;
      if (wr_en && sel_cfg) begin
        cfg_r <= pwdata[7:0];
      end
      if (wr_en && sel_rxq) begin
        rxq_r <= pwdata[1:0];
      end
      if (wr_en && sel_msk) begin
        imask_r <= pwdata[3:0];
      end
    end
  end

  wire logic [31:0] rd_mux = sel_cfg ? {24'h0, cfg_r} :
                             sel_mod ? {28'h0, mode_r} :
                             sel_ist ? {28'h0, ist_r} :
                             sel_msk ? {28'h0, imask_r} :
                             sel_sta ? {23'h0, rx_fill_level, tx_depth, rx_used} :
                             sel_rxq ? {30'h0, rxq_r} : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;
  assign rx_enable = mode_r[sfc_pkg::MODE_RXE_BIT];
  assign tx_enable = mode_r[sfc_pkg::MODE_TXE_BIT];
  assign irq       = |(ist_r & imask_r);

  sequence s_half_rx_full;
    auto_xfer_stop && duplex == sfc_pkg::DPX_HALF_RX && rx_full_cond;
  endsequence

  sequence s_half_tx_empty;
    auto_xfer_stop && duplex == sfc_pkg::DPX_HALF_TX && tx_empty_cond;
  endsequence

  sequence s_full_any;
    auto_xfer_stop && full_dpx && (rx_full_cond || tx_empty_cond);
  endsequence

  sequence s_rx_off;
    !rx_enable;
  endsequence

  sequence s_tx_off;
    !tx_enable;
  endsequence

  sequence s_both_off;
    !rx_enable && !tx_enable;
  endsequence

  a_rx_auto_stop: assert property (
    @(posedge clk) disable iff (rst)
    s_half_rx_full |=> s_rx_off
  ) else $error("Receive enable not cleared on stop");

  a_tx_auto_stop: assert property (
    @(posedge clk) disable iff (rst)
    s_half_tx_empty |=> s_tx_off
  ) else $error("Transmit enable not cleared on stop");

  a_full_both_stop: assert property (
    @(posedge clk) disable iff (rst)
    s_full_any |=> s_both_off
  ) else $error("Full duplex stop missed a direction");

  a_half_rx_scope: assert property (
    @(posedge clk) disable iff (rst)
    (auto_xfer_stop && duplex == sfc_pkg::DPX_HALF_RX && !(wr_en && sel_mod)) |=> tx_enable == $past(tx_enable)
  ) else $error("Half duplex receive stop touched transmit");

  a_half_tx_scope: assert property (
    @(posedge clk) disable iff (rst)
    (auto_xfer_stop && duplex == sfc_pkg::DPX_HALF_TX && !(wr_en && sel_mod)) |=> rx_enable == $past(rx_enable)
  ) else $error("Half duplex transmit stop touched receive");

  a_off_no_stop: assert property (
    @(posedge clk) disable iff (rst)
    (!fifo_en && !(wr_en && sel_mod)) |=> (rx_enable == $past(rx_enable) && tx_enable == $past(tx_enable))
  ) else $error("Enable changed with FIFO disabled");

  a_rx_stop_flag: assert property (
    @(posedge clk) disable iff (rst)
    (rx_stop && rx_enable) |=> ist_r[sfc_pkg::IRQ_RX_STOP_BIT]
  ) else $error("Receive stop not flagged");

  a_tx_stop_flag: assert property (
    @(posedge clk) disable iff (rst)
    (tx_stop && tx_enable) |=> ist_r[sfc_pkg::IRQ_TX_STOP_BIT]
  ) else $error("Transmit stop not flagged");

  a_no_duplex_stop: assert property (
    @(posedge clk) disable iff (rst)
    (duplex == sfc_pkg::DPX_OFF) |-> (!rx_stop && !tx_stop)
  ) else $error("Stop raised with no duplex selected");

  a_half_depth: assert property (
    @(posedge clk) disable iff (rst)
    (fifo_en && duplex == sfc_pkg::DPX_HALF_RX) |-> (rx_depth == 3'h4 && tx_depth == 3'h1)
  ) else $error("Half duplex receive depth wrong");

  a_half_tx_depth: assert property (
    @(posedge clk) disable iff (rst)
    (fifo_en && duplex == sfc_pkg::DPX_HALF_TX) |-> (rx_depth == 3'h1 && tx_depth == 3'h4)
  ) else $error("Half duplex transmit depth wrong");

  a_full_depth: assert property (
    @(posedge clk) disable iff (rst)
    (fifo_en && full_dpx) |-> (rx_depth == 3'h2 && tx_depth == 3'h2)
  ) else $error("Full duplex depth wrong");

  a_none_depth: assert property (
    @(posedge clk) disable iff (rst)
    (fifo_en && duplex == sfc_pkg::DPX_OFF) |-> (rx_depth == 3'h1 && tx_depth == 3'h1)
  ) else $error("Depth wrong with no duplex");

  a_off_depth: assert property (
    @(posedge clk) disable iff (rst)
    !fifo_en |-> (rx_depth == 3'h1 && tx_depth == 3'h1 && rx_used == 3'h1)
  ) else $error("Disabled depth wrong");

  a_tx_usage_free: assert property (
    @(posedge clk) disable iff (rst)
    ($past(fifo_en) && fifo_en && $stable(mode_r)) |-> $stable(tx_depth)
  ) else $error("Transmit depth moved with usage");

  a_rx_irq_gate: assert property (
    @(posedge clk) disable iff (rst)
    (!cfg_r[sfc_pkg::CFG_RX_IRQ_BIT] && !ist_r[sfc_pkg::IRQ_RX_LEVEL_BIT]) |=> !ist_r[sfc_pkg::IRQ_RX_LEVEL_BIT]
  ) else $error("Receive level irq not gated");

  a_rx_irq_set: assert property (
    @(posedge clk) disable iff (rst)
    (rx_level_evt && rx_level_irq_en) |=> ist_r[sfc_pkg::IRQ_RX_LEVEL_BIT]
  ) else $error("Receive level event lost");

  a_tx_irq_gate: assert property (
    @(posedge clk) disable iff (rst)
    (tx_level_evt && tx_level_irq_en) |=> ist_r[sfc_pkg::IRQ_TX_LEVEL_BIT]
  ) else $error("Transmit level event lost");

  a_tx_irq_off: assert property (
    @(posedge clk) disable iff (rst)
    (!cfg_r[sfc_pkg::CFG_TX_IRQ_BIT] && !ist_r[sfc_pkg::IRQ_TX_LEVEL_BIT]) |=> !ist_r[sfc_pkg::IRQ_TX_LEVEL_BIT]
  ) else $error("Transmit level irq not gated");

  a_off_irq_quiet: assert property (
    @(posedge clk) disable iff (rst)
    (!fifo_en && ist_r[1:0] == 2'h0) |=> ist_r[1:0] == 2'h0
  ) else $error("Level irq set with FIFO disabled");

  a_set_wins: assert property (
    @(posedge clk) disable iff (rst)
    (evt[sfc_pkg::IRQ_TX_LEVEL_BIT] && ist_clr[sfc_pkg::IRQ_TX_LEVEL_BIT]) |=> ist_r[sfc_pkg::IRQ_TX_LEVEL_BIT]
  ) else $error("Clear beat a same cycle event");

  a_usage_level: assert property (
    @(posedge clk) disable iff (rst)
    (fifo_en && cfg_r[sfc_pkg::CFG_RX_USAGE_BIT] && (duplex == sfc_pkg::DPX_HALF_RX || full_dpx)) |->
      rx_used == rx_fill_level
  ) else $error("Receive usage not level");

  a_usage_depth: assert property (
    @(posedge clk) disable iff (rst)
    !cfg_r[sfc_pkg::CFG_RX_USAGE_BIT] |-> rx_used == rx_depth
  ) else $error("Receive usage not full depth");

  a_usage_no_rx: assert property (
    @(posedge clk) disable iff (rst)
    (duplex == sfc_pkg::DPX_HALF_TX || duplex == sfc_pkg::DPX_OFF) |-> rx_used == 3'h1
  ) else $error("Receive usage without receive FIFO");

  a_half_level: assert property (
    @(posedge clk) disable iff (rst)
    (!full_dpx && rxq_r == 2'h0) |-> rx_fill_level == 3'h4
  ) else $error("Half duplex level 00 wrong");

  a_half_level_code: assert property (
    @(posedge clk) disable iff (rst)
    (!full_dpx && rxq_r != 2'h0) |-> rx_fill_level == {1'b0, rxq_r}
  ) else $error("Half duplex level code wrong");

  a_full_level: assert property (
    @(posedge clk) disable iff (rst)
    full_dpx |-> rx_fill_level == (rxq_r[0] ? 3'h1 : 3'h2)
  ) else $error("Full duplex level code wrong");
endmodule : sfc_top
`default_nettype wire

// ### bench/sfc_peer.sv
// Line peer model driving receive fill and transmit drain levels
`timescale 1ns/100ps
`default_nettype none
module sfc_peer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fill,
  input  wire logic       drain,
  output logic      [2:0] rx_count,
  output logic      [2:0] tx_count,
  output logic            rx_full,
  output logic            tx_empty
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_count <= 3'h0;
      tx_count <= 3'h3;
    end else begin
      rx_count <= !fill ? 3'h0 : (rx_count == 3'h4) ? rx_count : rx_count + 3'h1;
      tx_count <= !drain ? 3'h3 : (tx_count == 3'h0) ? tx_count : tx_count - 3'h1;
    end
  end
  assign rx_full  = fill && rx_count == 3'h4;
  assign tx_empty = drain && tx_count == 3'h0;
endmodule : sfc_peer
`default_nettype wire

// ### bench/sfc_top_tb.sv
// Self-checking bench for the FIFO configuration block
`timescale 1ns/100ps
`default_nettype none
module sfc_top_tb;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h7BC02DCB;
  logic        pready, pslverr, rx_full, tx_empty, rx_enable, tx_enable, irq;
  logic        rx_evt = 1'b0, tx_evt = 1'b0, fill = 1'b0, drain = 1'b0;
  logic [2:0]  rx_count, tx_count, rx_depth, tx_depth, rx_used, fl, xd, td, ud;
  logic [89:0] q[$];
  logic [89:0] e;
  int          n_mismatch = 0, num_checks = 0, dp, us, c;
  always #4 clk = ~clk;
  sfc_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_count(rx_count),
    .tx_count(tx_count), .rx_shift_full(rx_full), .rx_buf_full(rx_full), .tx_shift_empty(tx_empty),
    .tx_buf_empty(tx_empty), .rx_level_evt(rx_evt), .tx_level_evt(tx_evt), .rx_enable(rx_enable),
    .tx_enable(tx_enable), .rx_depth(rx_depth), .tx_depth(tx_depth), .rx_used(rx_used), .irq(irq));
  sfc_peer peer (.clk(clk), .rst(rst), .fill(fill), .drain(drain), .rx_count(rx_count),
    .tx_count(tx_count), .rx_full(rx_full), .tx_empty(tx_empty));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [2:0] lv(input bit f, input logic [1:0] k);
    return f ? (k[0] ? 3'h1 : 3'h2) : (k == 2'h0 ? 3'h4 : {1'b0, k});
  endfunction : lv
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdp(input logic [7:0] a, input logic [33:0] x, input logic [33:0] m, input logic [10:0] px,
                     input logic [10:0] pm);
    q.push_back({pm, px, m, x});
    apb(1'b0, a, 32'h0);
  endtask : rdp
  task automatic rd(input logic [7:0] a, input logic [33:0] x, input logic [33:0] m);
    rdp(a, x, m, 11'h000, 11'h000);
  endtask : rd
  task automatic pulse(input bit r);
    if (r) rx_evt <= 1'b1;
    else tx_evt <= 1'b1;
    @(posedge clk);
    rx_evt <= 1'b0;
    tx_evt <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic stop(input bit r);
    if (r) fill <= 1'b1;
    else drain <= 1'b1;
    repeat (8) @(posedge clk);
    fill <= 1'b0;
    drain <= 1'b0;
    @(posedge clk);
  endtask : stop
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      num_checks++;
      if ((({pslverr, irq, prdata} ^ e[33:0]) & e[67:34]) !== 34'h0 ||
          (({rx_enable, tx_enable, rx_depth, tx_depth, rx_used} ^ e[78:68]) & e[89:79]) !== 11'h000) begin
        n_mismatch++;
        $display("Error %0t: read %h got %h pins %h", $time, paddr, {pslverr, irq, prdata},
                 {rx_enable, tx_enable, rx_depth, tx_depth, rx_used});
      end
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 34'h0, 34'h3FFFFFFFF);
    rd(8'h10, 34'h9, 34'h3F);
    seed = lfsr(seed);
    wr(8'h20, seed);
    rd(8'h20, 34'h200000000, 34'h3FFFFFFFF);
    rd(8'h00, 34'h0, 34'hFF);
    for (dp = 0; dp < 4; dp++) begin
      wr(8'h04, {28'h0, dp[1:0], 2'b00});
      xd = (dp == 1) ? 3'h4 : (dp == 3) ? 3'h2 : 3'h1;
      td = (dp == 2) ? 3'h4 : (dp == 3) ? 3'h2 : 3'h1;
      for (us = 0; us < 2; us++) begin
        wr(8'h00, {27'h0, us[0], 4'h1});
        for (c = 0; c < 4; c++) begin
          wr(8'h14, {30'h0, c[1:0]});
          fl = lv(dp == 3, c[1:0]);
          ud = (us == 1 && xd != 3'h1) ? fl : xd;
          rdp(8'h10, {25'h0, fl, td, ud}, 34'h1FF, {2'b00, xd, td, ud}, 11'h7FF);
        end
      end
    end
    wr(8'h04, 32'hC);
    wr(8'h0C, 32'hF);
    wr(8'h00, 32'hD);
    pulse(0);
    rd(8'h08, 34'h100000001, 34'h3FFFFFFFF);
    wr(8'h08, 32'h1);
    rd(8'h08, 34'h0, 34'h3FFFFFFFF);
    pulse(1);
    rd(8'h08, 34'h100000002, 34'h3FFFFFFFF);
    wr(8'h0C, 32'h0);
    rd(8'h08, 34'h2, 34'h3FFFFFFFF);
    wr(8'h08, 32'h2);
    wr(8'h0C, 32'hF);
    wr(8'h00, 32'h1);
    pulse(0);
    pulse(1);
    rd(8'h08, 34'h0, 34'h3FFFFFFFF);
    wr(8'h00, 32'h3);
    wr(8'h04, 32'hF);
    stop(0);
    rdp(8'h04, 34'hC, 34'hF, 11'h092, 11'h7FF);
    wr(8'h04, 32'hF);
    stop(1);
    rdp(8'h04, 34'hC, 34'hF, 11'h092, 11'h7FF);
    wr(8'h04, 32'h5);
    stop(1);
    rdp(8'h04, 34'h4, 34'hF, 11'h10C, 11'h7FF);
    wr(8'h04, 32'hA);
    stop(0);
    rdp(8'h04, 34'h8, 34'hF, 11'h061, 11'h7FF);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h5);
    stop(1);
    rdp(8'h04, 34'h5, 34'hF, 11'h449, 11'h7FF);
    rd(8'h10, 34'h9, 34'h3F);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h04, 34'h0, 34'h3FFFFFFFF);
    rdp(8'h10, 34'h109, 34'h1FF, 11'h049, 11'h7FF);
    close_out();
  end
endmodule : sfc_top_tb
`default_nettype wire
